// ### rpsd_consts.vh
// constants for the reset pin sequencer and source detector
`ifndef RPSD_CONSTS_VH
`define RPSD_CONSTS_VH
// -----------------------------------------------------------------------------
// sequence timing, in self-reset clock ticks
// -----------------------------------------------------------------------------
`define RPSD_DRIVE_TICKS 34
`define RPSD_SAMPLE_TICKS 38
`define RPSD_TICK_W 6
// self-reset tick divider: mclk cycles per self-reset tick
`define RPSD_SELF_DIV 250
`define RPSD_DIV_W 8
// -----------------------------------------------------------------------------
// reset cause status field positions
// -----------------------------------------------------------------------------
`define RPSD_CAUSE_W 8
`define RPSD_BIT_POR 7
`define RPSD_BIT_PIN 6
`define RPSD_BIT_COP 5
`define RPSD_BIT_LVD 1
`define RPSD_CAUSE_RST 8'h80
`endif

// ### rpsd_tick_div.v
// one-cycle enable pulse divider for the self-reset clock
`timescale 1ns/100ps
`include "rpsd_consts.vh"
module rpsd_tick_div #(
    parameter DIV = `RPSD_SELF_DIV,
    parameter W = `RPSD_DIV_W
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_b,
    // control
    input wire i_run,
    output wire o_tick
);
    // period end, cut to the counter width on purpose
    localparam integer LAST_I = DIV - 1;
    localparam [W-1:0] LAST = LAST_I[W-1:0];
    reg [W-1:0] cnt;

    // restart at zero whenever idle so the first tick is a full period away
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= {W{1'b0}};
        end else if (!i_run || cnt == LAST) begin
            cnt <= {W{1'b0}};
        end else begin
            cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign o_tick = i_run && (cnt == LAST);
endmodule

// ### rpsd_top.v
// reset pin driver, release sampler and reset cause recorder
// What this block does
// - pin works as reset input/output only while the function enable is one
// - function enable returns to one after every reset of any kind
// - any reset drives the pin low for 34 self-reset ticks, then releases
// - pin is sampled 38 self-reset ticks after release
// - internal cause expects high sample; low sample means external reset
// - decoded cause sets its matching bit in the cause status register
`timescale 1ns/100ps
`include "rpsd_consts.vh"
module rpsd_top #(
    parameter DRIVE_TICKS = `RPSD_DRIVE_TICKS,
    parameter SAMPLE_TICKS = `RPSD_SAMPLE_TICKS,
    parameter SELF_DIV = `RPSD_SELF_DIV
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_b,
    // internal reset requests, one-cycle pulses or levels
    input wire i_por_req,
    input wire i_lvd_req,
    input wire i_cop_req,
    // software side: function enable clear and set, and port latch
    input wire i_fn_enable_clr,
    input wire i_fn_enable_set,
    input wire i_port_d_bit_one,
    // shared pin, open drain in reset mode
    input wire i_pin,
    output wire o_pin,
    output wire o_pin_oe_b,
    // status
    output reg o_reset_pin_function_enable,
    output reg [`RPSD_CAUSE_W-1:0] o_reset_cause_status_register,
    output reg o_sys_reset_b,
    output wire o_busy
);
    // -------------------------------------------------------------------------
    // sequencer states
    // -------------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DRIVE = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;
    // phase ends, cut to the tick counter width on purpose
    localparam integer DRIVE_LAST_I = DRIVE_TICKS - 1;
    localparam integer SAMPLE_LAST_I = SAMPLE_TICKS - 1;
    localparam [`RPSD_TICK_W-1:0] DRIVE_LAST = DRIVE_LAST_I[`RPSD_TICK_W-1:0];
    localparam [`RPSD_TICK_W-1:0] SAMPLE_LAST = SAMPLE_LAST_I[`RPSD_TICK_W-1:0];
    localparam [`RPSD_TICK_W-1:0] TICK_ONE = {{(`RPSD_TICK_W-1){1'b0}}, 1'b1};
    // status word for a reset that an outside source still holds on the pin
    localparam [`RPSD_CAUSE_W-1:0] CAUSE_PIN = {{(`RPSD_CAUSE_W-1){1'b0}}, 1'b1} << `RPSD_BIT_PIN;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`RPSD_TICK_W-1:0] ticks;
    reg [`RPSD_CAUSE_W-1:0] pend;   // internal causes seen in this sequence
    reg pin_low_d;
    wire tick;
    wire int_req;
    wire ext_req;
    wire seq_start;
    wire sample_now;

    // -------------------------------------------------------------------------
    // self-reset tick source
    // -------------------------------------------------------------------------
    rpsd_tick_div #(
        .DIV(SELF_DIV),
        .W(`RPSD_DIV_W)
    ) u_div (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_run(state == ST_DRIVE || state == ST_WAIT),
        .o_tick(tick)
    );

    // -------------------------------------------------------------------------
    // request decode
    // -------------------------------------------------------------------------
    assign int_req = i_por_req | i_lvd_req | i_cop_req;
    // a falling edge on the pin is an external request only in reset mode
    assign ext_req = o_reset_pin_function_enable && !i_pin && !pin_low_d;
    assign o_busy = (state != ST_IDLE);
    // a sequence only starts from idle; later internal requests just add causes
    assign seq_start = (state == ST_IDLE) && (next_state == ST_DRIVE);
    // the pin is judged on the edge that ends the release wait
    assign sample_now = (state == ST_WAIT) && (next_state == ST_DONE);

    // pin drive: low during the drive phase, port latch when function is off
    assign o_pin = o_reset_pin_function_enable ? 1'b0 : i_port_d_bit_one;
    assign o_pin_oe_b = o_reset_pin_function_enable ? (state != ST_DRIVE) : 1'b0;

    // edge memory for the pin; own drive does not count as a new request
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_low_d <= 1'b0;
        end else begin
            pin_low_d <= !i_pin;
        end
    end

    // -------------------------------------------------------------------------
    // sequencer next state
    // -------------------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (int_req || ext_req) begin
                    next_state = ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (tick && ticks == DRIVE_LAST) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick && ticks == SAMPLE_LAST) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // sequencer state and tick counter
    // -------------------------------------------------------------------------
    // after the async reset the block starts as if power-on had just occurred,
    // so the pin is pulsed and the cause is recorded like any other reset
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_DRIVE;
            ticks <= {`RPSD_TICK_W{1'b0}};
        end else begin
            state <= next_state;
            // each phase counts from zero; the divider itself runs on across
            // the drive-to-wait step, so no tick is lost between the phases
            if (state != next_state) begin
                ticks <= {`RPSD_TICK_W{1'b0}};
            end else if (tick) begin
                ticks <= ticks + TICK_ONE;
            end
        end
    end

    // -------------------------------------------------------------------------
    // system reset and pin function enable
    // -------------------------------------------------------------------------
    // a starting sequence outranks a software clear in the same cycle, so the
    // pin is never left in port mode once a reset has begun
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reset_pin_function_enable <= 1'b1;
            o_sys_reset_b <= 1'b0;
        end else if (seq_start) begin
            // new sequence: hold the system in reset, restore pin function
            o_sys_reset_b <= 1'b0;
            o_reset_pin_function_enable <= 1'b1;
        end else if (state == ST_DONE) begin
            o_sys_reset_b <= 1'b1;
        end else if (state == ST_IDLE) begin
            // clear has priority over set when software asks for both
            if (i_fn_enable_clr) begin
                o_reset_pin_function_enable <= 1'b0;
            end else if (i_fn_enable_set) begin
                o_reset_pin_function_enable <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // internal cause collection
    // -------------------------------------------------------------------------
    // requests that land while a sequence runs only add their cause; they
    // never restart the timing, so a chattering source cannot stall release
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend <= `RPSD_CAUSE_RST;
        end else begin
            if (seq_start) begin
                pend <= {`RPSD_CAUSE_W{1'b0}};
            end
            // the bit writes below override the clear for a starting cause
            if (seq_start || state != ST_IDLE) begin
                if (i_por_req) begin
                    pend[`RPSD_BIT_POR] <= 1'b1;
                end
                if (i_lvd_req) begin
                    pend[`RPSD_BIT_LVD] <= 1'b1;
                end
                if (i_cop_req) begin
                    pend[`RPSD_BIT_COP] <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // release sample and cause status
    // -------------------------------------------------------------------------
    // an outside source still holding the pin low outranks every internal
    // cause; a heavily loaded pin therefore reads as external every time
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reset_cause_status_register <= `RPSD_CAUSE_RST;
        end else if (sample_now) begin
            if (!i_pin) begin
                o_reset_cause_status_register <= CAUSE_PIN;
            end else begin
                o_reset_cause_status_register <= pend;
            end
        end
    end
endmodule

// ### rpsd_monitor.sv
// port checker for the reset pin sequencer and cause recorder
`timescale 1ns/100ps
module rpsd_monitor #(parameter DRIVE_TICKS = 34, parameter SAMPLE_TICKS = 38, parameter SELF_DIV = 250) (
    // clock, reset and requests
    input wire i_mclk, i_rst_b, i_por_req, i_lvd_req, i_cop_req, i_pin,
    // software side
    input wire i_fn_enable_clr, i_fn_enable_set, i_port_d_bit_one,
    // outputs of the block
    input wire o_pin, o_pin_oe_b, o_reset_pin_function_enable, o_sys_reset_b, o_busy,
    input wire [7:0] o_reset_cause_status_register
);
    localparam int DRV_LEN = DRIVE_TICKS * SELF_DIV;
    localparam int WT_LEN = SAMPLE_TICKS * SELF_DIV;
    wire idle_port = !o_busy && !o_reset_pin_function_enable;
    wire no_req = !i_por_req && !i_lvd_req && !i_cop_req;
    int drv_cnt;
    int wt_cnt;
    // phases last thousands of cycles, so they are counted rather than delayed
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drv_cnt <= 0;
            wt_cnt <= 0;
        end else begin
            drv_cnt <= (o_busy && !o_pin_oe_b) ? drv_cnt + 1 : 0;
            wt_cnt <= (o_busy && o_pin_oe_b) ? wt_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // last driven cycle, then the pin is let go
    sequence s_drive;
        (!o_pin_oe_b && !o_pin) ##1 (o_busy && o_pin_oe_b);
    endsequence
    // last busy cycle, then the sequencer goes idle
    sequence s_wait;
        (o_busy && o_pin_oe_b) ##1 !o_busy;
    endsequence
    property p_drive; s_drive |-> drv_cnt == DRV_LEN; endproperty
    a_drive: assert property (p_drive) else $error("drive span wrong");
    property p_low; o_busy && !o_pin_oe_b |-> !o_pin && drv_cnt < DRV_LEN; endproperty
    a_low: assert property (p_low) else $error("drive too long or pin not low");
    property p_wait; s_wait |-> o_sys_reset_b && wt_cnt == WT_LEN + 1; endproperty
    a_wait: assert property (p_wait) else $error("sample wait wrong");
    property p_en; $rose(o_busy) |-> o_reset_pin_function_enable; endproperty
    a_en: assert property (p_en) else $error("enable not set by reset");
    property p_clr; !o_busy && i_fn_enable_clr && no_req && i_pin |=> !o_reset_pin_function_enable; endproperty
    a_clr: assert property (p_clr) else $error("enable clear lost");
    property p_port; idle_port |-> (!o_pin_oe_b && o_pin == i_port_d_bit_one); endproperty
    a_port: assert property (p_port) else $error("port mode pin wrong");
    property p_ign; idle_port && no_req |=> !o_busy; endproperty
    a_ign: assert property (p_ign) else $error("pin taken in port mode");
    property p_take; !o_busy && o_reset_pin_function_enable && $fell(i_pin) |=> (o_busy && !o_sys_reset_b); endproperty
    a_take: assert property (p_take) else $error("pin reset not taken");
    property p_ext; $rose(o_sys_reset_b) && !$past(i_pin, 2) |-> o_reset_cause_status_register == 8'h40; endproperty
    a_ext: assert property (p_ext) else $error("external cause wrong");
    property p_int; $rose(o_sys_reset_b) && $past(i_pin, 2) |-> o_reset_cause_status_register[6] == 1'b0 &&
        o_reset_cause_status_register != 8'h00; endproperty
    a_int: assert property (p_int) else $error("internal cause wrong");
endmodule
bind rpsd_top rpsd_monitor #(.DRIVE_TICKS(DRIVE_TICKS), .SAMPLE_TICKS(SAMPLE_TICKS), .SELF_DIV(SELF_DIV)) u_mon (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_por_req(i_por_req), .i_lvd_req(i_lvd_req), .i_cop_req(i_cop_req),
    .i_pin(i_pin), .i_fn_enable_clr(i_fn_enable_clr), .i_fn_enable_set(i_fn_enable_set),
    .i_port_d_bit_one(i_port_d_bit_one), .o_pin(o_pin), .o_pin_oe_b(o_pin_oe_b), .o_busy(o_busy),
    .o_reset_pin_function_enable(o_reset_pin_function_enable), .o_sys_reset_b(o_sys_reset_b),
    .o_reset_cause_status_register(o_reset_cause_status_register));

// ### rpsd_board.sv
// board side of the shared pin: pull-up and an external reset source
`timescale 1ns/100ps
module rpsd_board (
    input wire i_drv,
    input wire i_drv_oe_b,
    input wire i_hold,
    output wire o_level
);
    // external source wins; a released pin floats up through the pull-up
    assign o_level = i_hold ? 1'b0 : (i_drv_oe_b ? 1'b1 : i_drv);
endmodule

// ### testbench.sv
// self-checking bench for the reset pin sequencer
`timescale 1ns/100ps
module testbench;
    reg i_mclk = 0, i_rst_b = 0, clr = 0, set = 0, latch = 1, hold = 0;
    reg [2:0] rq = 0;
    wire pin, o_pin, oe_b, en, sysr, busy;
    wire [7:0] cause;
    int error_cnt = 0, check_count = 0, k;
    always #2 i_mclk = ~i_mclk;
    // short tick divider keeps each sequence near 150 cycles
    rpsd_top #(.SELF_DIV(2)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_por_req(rq[0]), .i_lvd_req(rq[1]),
        .i_cop_req(rq[2]), .i_fn_enable_clr(clr), .i_fn_enable_set(set), .i_port_d_bit_one(latch), .i_pin(pin),
        .o_pin(o_pin), .o_pin_oe_b(oe_b), .o_reset_pin_function_enable(en), .o_reset_cause_status_register(cause),
        .o_sys_reset_b(sysr), .o_busy(busy));
    rpsd_board board (.i_drv(o_pin), .i_drv_oe_b(oe_b), .i_hold(hold), .o_level(pin));
    function [7:0] exp_cause(input [2:0] r);
        exp_cause = {r[0], 1'b0, r[2], 3'b000, r[1], 1'b0};
    endfunction
    task chk(input string nm, input [7:0] exp, input [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // bounded wait for the sequence to finish
    task idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        chk("busy", 8'h00, busy);
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #40000;
        error_cnt++;
        results;
    end
    initial begin
        k = $urandom(24);
        tick(5);
        i_rst_b = 1;
        idle;
        chk("power on cause", 8'h80, cause);
        chk("enable", 8'h01, en);
        // every mix of requests, the rest arriving mid-sequence
        for (k = 1; k < 8; k++) begin
            clr = $urandom % 2;
            tick(1);
            clr = 0;
            tick($urandom % 5 + 1);
            rq = k[2:0] & (~k[2:0] + 3'b001);
            tick(1);
            rq = 0;
            tick($urandom % 50 + 2);
            rq = k[2:0];
            tick(1);
            rq = 0;
            idle;
            chk("cause", exp_cause(k[2:0]), cause);
            chk("sys reset", 8'h01, sysr);
            chk("enable", 8'h01, en);
            $display("test internal %0d done", k);
        end
        // external hold low past the sample point, internal requests mixed in
        for (k = 0; k < 3; k++) begin
            hold = 1;
            tick(10);
            rq = k[2:0];
            tick(1);
            rq = 0;
            tick($urandom % 100 + 200);
            hold = 0;
            idle;
            chk("external cause", 8'h40, cause);
            $display("test external %0d done", k);
        end
        // port mode: latch drives the pin, low levels start nothing
        clr = 1;
        tick(1);
        clr = 0;
        for (k = 0; k < 20; k++) begin
            latch = $urandom % 2;
            tick(1);
            chk("port pin", latch, pin);
            chk("port busy", 8'h00, busy);
        end
        latch = 1;
        set = 1;
        tick(1);
        set = 0;
        tick(1);
        chk("enable set", 8'h01, en);
        $display("test port done");
        // reset in mid-sequence restarts as power-on
        rq = 3'b100;
        tick(1);
        rq = 0;
        tick($urandom % 100 + 5);
        i_rst_b = 0;
        tick(2);
        i_rst_b = 1;
        idle;
        chk("reset cause", 8'h80, cause);
        $display("test mid reset done");
        results;
    end
endmodule
